// file: core/cpx_exception_regs.v
// coprocessor-0 exception processing register set
// Notes on behaviour
// - synchronous exception saves faulting pc, or branch pc with delay flag
// - exception restart pc frozen while exception level is set
// - identity: revision in bits 7:0, implementation in 15:8
// - identity upper halfword reads zero
// - revision major in 7:4, minor in 3:0
// - config 31:3 loaded at reset, read-only; 2:0 software field
// - software config field has no defined reset value
// - fetch address 31:2 match with enable raises instruction watch
// - load/store address 31:3 match with read/write enable raises data watch
// - watch matches under exception or error level are held pending
// - watch exceptions rank just below matching address errors
// - cache maintenance operations never raise data watch
// - parity override drives store parity while override bit set
// - override loaded by index-load-tag, replaces fill parity
// - cache error capture loads on cache error, also on bad read parity
// - tag staging written by cache and move; parity ignored on store tag
// - error restart pc saved on parity error, reset, soft reset, nmi
// - error restart pc has no delay indication, holds branch pc
// - exception sets exception level, return clears it
// - cold reset clears soft reset flag, sets error level and boot vectors
`timescale 1ns/1ps
`include "cpx_defs.vh"
module cpx_exception_regs #(
    parameter [7:0]  IMPL_NUM  = 8'h5a, // arbitrary value
    parameter [3:0]  REV_MAJOR = 4'h1,  // arbitrary value
    parameter [3:0]  REV_MINOR = 4'h0   // arbitrary value
) (
    // clock and reset
    input  wire        mclk_i,
    input  wire        rst_i,
    // hardware straps for config 31:3
    input  wire [28:0] cfg_strap_i,
    // coprocessor move port
    input  wire        mt_en_i,
    input  wire [4:0]  mt_sel_i,
    input  wire [31:0] mt_data_i,
    input  wire [4:0]  mf_sel_i,
    output reg  [31:0] mf_data_o,
    // exception events from pipeline
    input  wire        exc_take_i,
    input  wire        exc_pc_dly_i,
    input  wire [31:0] exc_pc_i,
    input  wire [31:0] exc_br_pc_i,
    input  wire        exc_ret_i,
    input  wire        err_exc_i,
    input  wire        soft_reset_i,
    input  wire        nmi_i,
    // watch inputs
    input  wire        fetch_vld_i,
    input  wire [31:0] fetch_addr_i,
    input  wire        fetch_adel_i,
    input  wire        ls_vld_i,
    input  wire        ls_store_i,
    input  wire        ls_cacheop_i,
    input  wire [31:0] ls_addr_i,
    input  wire        ls_ade_i,
    // cache interface
    input  wire        idx_load_tag_i,
    input  wire [7:0]  idx_par_i,
    input  wire [31:0] idx_tag_i,
    input  wire        idx_store_tag_i,
    input  wire        cache_err_i,
    input  wire        rd_bad_par_i,
    input  wire [31:0] cache_err_info_i,
    // outputs
    output wire [7:0]  par_override_o,
    output wire        par_override_en_o,
    output wire [31:0] tag_store_o,
    output wire        iwatch_exc_o,
    output wire        dwatch_exc_o,
    output wire        cache_err_exc_o,
    output wire        branch_delay_o,
    output wire        kernel_mode_o,
    output wire        bootstrap_vectors_o
);
    reg [31:0] exception_restart_pc;
    reg [31:0] error_restart_pc;
    reg [31:0] debug_restart_pc;
    reg [31:0] debug_control_status;
    reg [31:0] cache_error_capture;
    reg [31:0] cache_tag_staging;
    reg [7:0]  cache_parity_override;
    reg [31:0] instruction_watch_point;
    reg [31:0] data_watch_point;
    reg [28:0] cfg_hw;
    // left out of reset on purpose, software must load it
    reg [2:0]  kseg_cacheability;
    reg        exception_level;
    reg        error_level;
    reg        user_mode_select;
    reg        soft_reset_flag;
    reg        bootstrap_vectors;
    reg        parity_override_en;
    reg        branch_delay;
    reg        iw_pend;
    reg        dw_pend;

    wire lvl_busy = exception_level | error_level;
    wire [29:0] fetch_watch_address = instruction_watch_point[31:2];
    wire [28:0] load_store_watch_address = data_watch_point[31:3];
    wire i_hit = fetch_vld_i & ~fetch_adel_i
        & instruction_watch_point[`CPX_IW_EN]
        & (fetch_addr_i[31:2] == fetch_watch_address);
    wire d_hit = ls_vld_i & ~ls_cacheop_i & ~ls_ade_i
        & (ls_addr_i[31:3] == load_store_watch_address)
        & (ls_store_i ? data_watch_point[`CPX_DW_WR]
                      : data_watch_point[`CPX_DW_RD]);
    wire ce_exc = cache_err_i | rd_bad_par_i;
    wire any_reset_exc = soft_reset_i | nmi_i;
    wire [31:0] restart_pc = exc_pc_dly_i ? exc_br_pc_i : exc_pc_i;

    assign iwatch_exc_o = ~lvl_busy & (i_hit | iw_pend);
    assign dwatch_exc_o = ~lvl_busy & (d_hit | dw_pend);
    assign cache_err_exc_o = ce_exc;
    assign par_override_o = cache_parity_override;
    assign par_override_en_o = parity_override_en;
    assign tag_store_o = {cache_tag_staging[31:1], 1'b0};
    assign branch_delay_o = branch_delay;
    assign kernel_mode_o = lvl_busy | ~user_mode_select;
    assign bootstrap_vectors_o = bootstrap_vectors;

    wire wr = mt_en_i;
    always @(posedge mclk_i) begin
        if (rst_i) begin
            exception_level    <= 1'b0;
            error_level        <= 1'b1;
            bootstrap_vectors  <= 1'b1;
            soft_reset_flag    <= 1'b0;
            user_mode_select   <= 1'b0;
            parity_override_en <= 1'b0;
            branch_delay       <= 1'b0;
            iw_pend            <= 1'b0;
            dw_pend            <= 1'b0;
            instruction_watch_point[`CPX_IW_EN] <= 1'b0;
            data_watch_point[`CPX_DW_WR] <= 1'b0;
            data_watch_point[`CPX_DW_RD] <= 1'b0;
            cfg_hw             <= cfg_strap_i;
            error_restart_pc   <= exc_pc_i;
        end else begin
            // software moves, read-only targets fall through
            if (wr && mt_sel_i == `CPX_REG_EXC_PC)
                exception_restart_pc <= mt_data_i;
            if (wr && mt_sel_i == `CPX_REG_CONFIG)
                kseg_cacheability <= mt_data_i[2:0];
            if (wr && mt_sel_i == `CPX_REG_IWATCH)
                instruction_watch_point <= mt_data_i;
            if (wr && mt_sel_i == `CPX_REG_DWATCH)
                data_watch_point <= mt_data_i;
            if (wr && mt_sel_i == `CPX_REG_DBG_PC)
                debug_restart_pc <= mt_data_i;
            if (wr && mt_sel_i == `CPX_REG_DBG_CTL)
                debug_control_status <= mt_data_i;
            if (wr && mt_sel_i == `CPX_REG_PAR_OVR)
                cache_parity_override <= mt_data_i[7:0];
            if (wr && mt_sel_i == `CPX_REG_ERR_PC)
                error_restart_pc <= mt_data_i;
            if (wr && mt_sel_i == `CPX_REG_TAG)
                cache_tag_staging <= mt_data_i;
            if (wr && mt_sel_i == `CPX_REG_STATUS) begin
                exception_level    <= mt_data_i[`CPX_ST_EXL];
                error_level        <= mt_data_i[`CPX_ST_ERL];
                user_mode_select   <= mt_data_i[`CPX_ST_UM];
                soft_reset_flag    <= mt_data_i[`CPX_ST_SRF];
                bootstrap_vectors  <= mt_data_i[`CPX_ST_BEV];
                parity_override_en <= mt_data_i[`CPX_ST_CPO];
            end
            // cache operations load staging and override
            if (idx_load_tag_i) begin
                cache_parity_override <= idx_par_i;
                cache_tag_staging <= idx_tag_i;
            end
            if (ce_exc)
                cache_error_capture <= cache_err_info_i;
            // watch pending, set wins over taking
            if (lvl_busy) begin
                if (i_hit)
                    iw_pend <= 1'b1;
                if (d_hit)
                    dw_pend <= 1'b1;
            end else begin
                iw_pend <= 1'b0;
                dw_pend <= 1'b0;
            end
            if (exc_ret_i)
                exception_level <= 1'b0;
            if (exc_take_i) begin
                exception_level <= 1'b1;
                if (!exception_level) begin
                    exception_restart_pc <= restart_pc;
                    branch_delay <= exc_pc_dly_i;
                end
            end
            if (ce_exc || err_exc_i || any_reset_exc) begin
                error_restart_pc <= restart_pc;
                error_level <= 1'b1;
            end
            if (any_reset_exc) begin
                soft_reset_flag   <= 1'b1;
                bootstrap_vectors <= 1'b1;
            end
        end
    end

    // move-from read mux
    always @(posedge mclk_i) begin
        if (rst_i)
            mf_data_o <= `CPX_ZERO32;
        else begin
            case (mf_sel_i)
                `CPX_REG_EXC_PC:  mf_data_o <= exception_restart_pc;
                `CPX_REG_IDENT:   mf_data_o <= {16'h0000, IMPL_NUM,
                                        REV_MAJOR, REV_MINOR};
                `CPX_REG_CONFIG:  mf_data_o <= {cfg_hw, kseg_cacheability};
                `CPX_REG_STATUS:  mf_data_o <= {9'h000,
                    bootstrap_vectors, 1'b0, soft_reset_flag, 2'b00,
                    parity_override_en, 12'h000, user_mode_select,
                    1'b0, error_level, exception_level, 1'b0};
                `CPX_REG_IWATCH:  mf_data_o <= instruction_watch_point;
                `CPX_REG_DWATCH:  mf_data_o <= data_watch_point;
                `CPX_REG_DBG_PC:  mf_data_o <= debug_restart_pc;
                `CPX_REG_DBG_CTL: mf_data_o <= debug_control_status;
                `CPX_REG_PAR_OVR: mf_data_o <= {24'h00_0000,
                                                cache_parity_override};
                `CPX_REG_CERR:    mf_data_o <= cache_error_capture;
                `CPX_REG_TAG:     mf_data_o <= cache_tag_staging;
                `CPX_REG_ERR_PC:  mf_data_o <= error_restart_pc;
                default:          mf_data_o <= `CPX_ZERO32;
            endcase
        end
    end
endmodule

// file: core/cpx_defs.vh
// register numbers, field positions and reset values of the exception set
`ifndef CPX_DEFS_VH
`define CPX_DEFS_VH
`define CPX_REG_EXC_PC      5'h0e
`define CPX_REG_IDENT       5'h0f
`define CPX_REG_CONFIG      5'h10
`define CPX_REG_STATUS      5'h0c
`define CPX_REG_IWATCH      5'h12
`define CPX_REG_DWATCH      5'h13
`define CPX_REG_DBG_PC      5'h17
`define CPX_REG_DBG_CTL     5'h18
`define CPX_REG_PAR_OVR     5'h1a
`define CPX_REG_CERR        5'h1b
`define CPX_REG_TAG         5'h1c
`define CPX_REG_ERR_PC      5'h1e
// status bit positions
`define CPX_ST_EXL          1
`define CPX_ST_ERL          2
`define CPX_ST_UM           4
`define CPX_ST_SRF          20
`define CPX_ST_BEV          22
`define CPX_ST_CPO          17
// watch enable bits
`define CPX_IW_EN           0
`define CPX_DW_WR           0
`define CPX_DW_RD           1
// tag staging parity bit
`define CPX_TAG_PAR         0
// configuration read/write field width
`define CPX_CFG_K0_W        3
`define CPX_ZERO32          32'h0000_0000
`endif

// file: dv/cpx_exc_chk.sv
// port assertions for the exception register set
`timescale 1ns/1ps
module cpx_exc_chk (
    input wire        mclk_i, rst_i, mt_en_i, exc_take_i, exc_ret_i,
    input wire        fetch_adel_i, ls_vld_i, ls_cacheop_i, ls_ade_i,
    input wire        idx_load_tag_i, cache_err_i, rd_bad_par_i,
    input wire        iwatch_exc_o, dwatch_exc_o, cache_err_exc_o,
    input wire        branch_delay_o, kernel_mode_o, bootstrap_vectors_o,
    input wire [4:0]  mt_sel_i, mf_sel_i,
    input wire [7:0]  idx_par_i, par_override_o,
    input wire [28:0] cfg_strap_i,
    input wire [31:0] mt_data_i, mf_data_o, tag_store_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    property p_cerr; cache_err_exc_o == (cache_err_i | rd_bad_par_i);
    endproperty
    property p_rst; $fell(rst_i) |-> kernel_mode_o && bootstrap_vectors_o;
    endproperty
    property p_kern; exc_take_i && !exc_ret_i && !mt_en_i |=> kernel_mode_o;
    endproperty
    property p_iadel; fetch_adel_i |-> !iwatch_exc_o; endproperty
    property p_dade; ls_ade_i |-> !dwatch_exc_o; endproperty
    property p_cop; ls_vld_i && ls_cacheop_i |-> !dwatch_exc_o; endproperty
    property p_par; idx_load_tag_i |=> par_override_o == $past(idx_par_i);
    endproperty
    property p_tag; mt_en_i && mt_sel_i == 5'h1c && !idx_load_tag_i |=>
        tag_store_o == ($past(mt_data_i) & 32'hffff_fffe); endproperty
    property p_ident; $past(mf_sel_i) == 5'h0f |-> mf_data_o[31:16] == 0;
    endproperty
    property p_cfg; $past(mf_sel_i) == 5'h10 |->
        mf_data_o[31:3] == cfg_strap_i; endproperty
    a_cerr: assert property (p_cerr) else $error("cache exc wrong");
    a_rst: assert property (p_rst) else $error("reset levels wrong");
    a_kern: assert property (p_kern) else $error("not kernel");
    a_iadel: assert property (p_iadel) else $error("iwatch rank");
    a_dade: assert property (p_dade) else $error("dwatch rank");
    a_cop: assert property (p_cop) else $error("cache op watch");
    a_par: assert property (p_par) else $error("override load");
    a_tag: assert property (p_tag) else $error("tag write");
    a_ident: assert property (p_ident) else $error("ident upper");
    a_cfg: assert property (p_cfg) else $error("config strap");
    c_iw: cover property (iwatch_exc_o);
    c_dw: cover property (dwatch_exc_o);
    c_ce: cover property (cache_err_exc_o);
    c_bd: cover property (branch_delay_o);
endmodule
bind cpx_exception_regs cpx_exc_chk i_cpx_exc_chk (.*);

// file: dv/cpx_pipe_model.sv
// pipeline model: access requests to fetch and load/store strobes
`timescale 1ns/1ps
module cpx_pipe_model (
    input  wire [2:0]  op_i,   // 0 idle 1 fetch 2 load 3 store 4 cache op
    input  wire [31:0] addr_i,
    output wire        fetch_vld_o,
    output wire        ls_vld_o,
    output wire        ls_store_o,
    output wire        ls_cacheop_o,
    output wire [31:0] addr_o
);
    assign fetch_vld_o  = (op_i == 3'h1);
    assign ls_vld_o     = (op_i >= 3'h2);
    assign ls_store_o   = (op_i == 3'h3);
    assign ls_cacheop_o = (op_i == 3'h4);
    // idle bus shows inverse of last address
    assign addr_o       = (op_i == 3'h0) ? ~addr_i : addr_i;
endmodule

// file: dv/tb_cpx_exception_regs.sv
// self-checking bench for the exception register set
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
    $display("Error %s exp %h got %h", n, e, a); error_cnt++; end end
module tb_cpx_exception_regs;
    localparam [28:0] STRAP = 29'h0a5_5a5a;
    reg mclk_i = 0, rst_i = 1, mt_en_i = 0, exc_take_i = 0, exc_ret_i = 0;
    reg exc_pc_dly_i = 0, err_exc_i = 0, soft_reset_i = 0, nmi_i = 0;
    reg fetch_adel_i = 0, ls_ade_i = 0, idx_load_tag_i = 0, cache_err_i = 0;
    reg idx_store_tag_i = 0, rd_bad_par_i = 0;
    reg [2:0]  op = 0;
    reg [4:0]  mt_sel_i = 0, mf_sel_i = 0;
    reg [7:0]  idx_par_i = 0;
    reg [28:0] cfg_strap_i = STRAP;
    reg [31:0] mt_data_i = 0, exc_pc_i = 0, exc_br_pc_i = 0, req_addr = 0;
    reg [31:0] idx_tag_i = 0, cache_err_info_i = 0, v;
    wire fetch_vld_i, ls_vld_i, ls_store_i, ls_cacheop_i, par_override_en_o;
    wire iwatch_exc_o, dwatch_exc_o, cache_err_exc_o, branch_delay_o;
    wire kernel_mode_o, bootstrap_vectors_o;
    wire [7:0]  par_override_o;
    wire [31:0] mf_data_o, tag_store_o, fetch_addr_i, ls_addr_i;
    integer error_cnt = 0, checks_done = 0;
    assign ls_addr_i = fetch_addr_i;
    always #5 mclk_i = ~mclk_i;
    cpx_exception_regs i_cpx_exception_regs (.*);
    cpx_pipe_model i_cpx_pipe_model (.op_i(op), .addr_i(req_addr),
        .fetch_vld_o(fetch_vld_i), .ls_vld_o(ls_vld_i),
        .ls_store_o(ls_store_i), .ls_cacheop_o(ls_cacheop_i),
        .addr_o(fetch_addr_i));
    task wr(input [4:0] s, input [31:0] d); begin
        @(posedge mclk_i) {mt_en_i, mt_sel_i, mt_data_i} <= {1'b1, s, d};
        @(posedge mclk_i) mt_en_i <= 1'b0;
    end endtask
    task rd(input [4:0] s); begin
        @(posedge mclk_i) mf_sel_i <= s;
        @(posedge mclk_i) #1 v = mf_data_o;
    end endtask
    // k = {take, return, soft reset, nmi}
    task ev(input [3:0] k, input dl, input [31:0] pc); begin
        @(posedge mclk_i) {exc_take_i, exc_ret_i, soft_reset_i, nmi_i} <= k;
        {exc_pc_dly_i, exc_pc_i, exc_br_pc_i} <= {dl, pc, pc - 32'h0000_0004};
        @(posedge mclk_i) {exc_take_i, exc_ret_i, soft_reset_i, nmi_i} <= 0;
        #1;
    end endtask
    // x = {address error, iwatch expected, dwatch expected}
    task acc(input [2:0] o, input [31:0] a, input [2:0] x); begin
        @(posedge mclk_i) {op, req_addr, fetch_adel_i, ls_ade_i} <=
            {o, a, x[2], x[2]};
        #1 `CHK("iwatch", x[1], iwatch_exc_o)
        `CHK("dwatch", x[0], dwatch_exc_o)
        @(posedge mclk_i) {op, fetch_adel_i, ls_ade_i} <= 0;
    end endtask
    task t_regs; begin
        rd(5'h0c);
        `CHK("levels", 3'h5, {v[22], v[20], v[2]})
        `CHK("boot", 1'b1, bootstrap_vectors_o & kernel_mode_o)
        wr(5'h0f, 32'hffff_ffff);
        rd(5'h0f);
        `CHK("identity", 32'h0000_5a10, v)
        wr(5'h10, 32'hffff_fff5);
        rd(5'h10);
        `CHK("config", {STRAP, 3'h5}, v)
    end endtask
    task t_epc; begin
        wr(5'h0c, 32'h0000_0010);
        #1 `CHK("user", 1'b0, kernel_mode_o)
        ev(4'h8, 1'b0, 32'h0000_1000);
        `CHK("kernel", 1'b1, kernel_mode_o)
        ev(4'h8, 1'b1, 32'h0000_2000);
        rd(5'h0e);
        `CHK("exc pc", 32'h0000_1000, v)
        ev(4'h4, 1'b0, 32'h0000_0000);
        `CHK("return", 1'b0, kernel_mode_o)
        ev(4'h8, 1'b1, 32'h0000_3000);
        rd(5'h0e);
        `CHK("branch pc", {32'h0000_2ffc, 1'b1}, {v, branch_delay_o})
        ev(4'h4, 1'b0, 32'h0000_0000);
    end endtask
    task t_watch; begin
        wr(5'h12, 32'h1000_0001);
        wr(5'h13, 32'h2000_0003);
        acc(3'h1, 32'h1000_0003, 3'b010);
        acc(3'h1, 32'h1000_0004, 3'b000);
        acc(3'h1, 32'h1000_0000, 3'b100);
        acc(3'h2, 32'h2000_0007, 3'b001);
        acc(3'h3, 32'h2000_0000, 3'b001);
        acc(3'h2, 32'h2000_0008, 3'b000);
        acc(3'h4, 32'h2000_0000, 3'b000);
        acc(3'h2, 32'h2000_0000, 3'b100);
        wr(5'h13, 32'h2000_0001);
        acc(3'h2, 32'h2000_0000, 3'b000);
        wr(5'h0c, 32'h0000_0002);
        acc(3'h1, 32'h1000_0000, 3'b000);
        wr(5'h0c, 32'h0000_0000);
        #1 `CHK("pending", 1'b1, iwatch_exc_o)
    end endtask
    task t_cache; begin
        @(posedge mclk_i) {idx_load_tag_i, idx_par_i} <= {1'b1, 8'ha5};
        @(posedge mclk_i) idx_load_tag_i <= 1'b0;
        #1 `CHK("override", 8'ha5, par_override_o)
        wr(5'h0c, 32'h0002_0000);
        #1 `CHK("override en", 1'b1, par_override_en_o)
        wr(5'h1c, 32'hffff_ffff);
        #1 `CHK("tag", 32'hffff_fffe, tag_store_o)
        @(posedge mclk_i) {cache_err_i, cache_err_info_i} <=
            {1'b1, 32'h0123_4567};
        #1 `CHK("cache exc", 1'b1, cache_err_exc_o)
        @(posedge mclk_i) {cache_err_i, rd_bad_par_i} <= 2'b01;
        #1 `CHK("bad parity", 1'b1, cache_err_exc_o)
        @(posedge mclk_i) rd_bad_par_i <= 1'b0;
        wr(5'h1b, 32'h0000_0000);
        rd(5'h1b);
        `CHK("cache err", 32'h0123_4567, v)
        ev(4'h2, 1'b1, 32'h0000_4000);
        rd(5'h1e);
        `CHK("err pc soft", 32'h0000_3ffc, v)
        ev(4'h1, 1'b0, 32'h0000_5000);
        rd(5'h1e);
        `CHK("err pc nmi", 32'h0000_5000, v)
    end endtask
    task results; begin
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end endtask
    initial begin
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_regs;
        t_epc;
        t_watch;
        t_cache;
        results;
    end
    initial begin
        repeat (5000) @(posedge mclk_i);
        error_cnt++;
        results;
    end
endmodule
